// ==== hdl/usb_hub_sie.v ====
`timescale 1ns/100ps
`include "usb_hub_sie_consts.vh"
module usb_hub_sie (
    input  wire        clk,
    input  wire        resetn,
    input  wire        por_n,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Line events from the serial engine
    input  wire        packet_end_seen,
    input  wire        bus_activity_seen,
    input  wire        frame_start_seen,
    input  wire        frame_end2_point,
    input  wire        frame_lock_seen,
    input  wire        bus_reset_seen,
    // Token interface, hub endpoint 0
    input  wire        token_valid,
    input  wire [1:0]  token_kind,
    input  wire [6:0]  token_addr,
    input  wire [3:0]  token_endp,
    input  wire        tx_acked,
    input  wire        rx_acked,
    output reg  [1:0]  handshake,
    output reg         send_data,
    output reg         accept_data,
    output reg         data_pid_one,
    output reg  [3:0]  tx_byte_count,
    // System
    output wire        usb_irq,
    output reg         system_reset,
    output wire        regulator_output,
    output wire        transceiver_enable
);
    localparam [1:0] TOK_OUT   = 2'h0;
    localparam [1:0] TOK_IN    = 2'h1;
    localparam [1:0] TOK_SETUP = 2'h2;

    // ************************************************
    // Register state
    // ************************************************
    reg  [3:0] flags_reg;
    reg  [3:0] flags_next;
    reg  [3:0] fr_ie_reg;
    reg        rst_f_reg;
    reg        lock_f_reg;
    reg        mod_en_reg;
    reg  [6:0] addr_reg;
    reg        tx_f_reg;
    reg        rx_f_reg;
    reg        tx_ie_reg;
    reg        rx_ie_reg;
    reg        toggle_reg;
    reg        stall_reg;
    reg        tx_en_reg;
    reg        rx_en_reg;
    reg  [3:0] count_reg;
    reg        ack_reg;

    wire [3:0] word = avs_address[5:2];
    wire       wr = avs_write & avs_byteenable[0] & ~ack_reg;
    wire [7:0] wd = avs_writedata[7:0];
    wire       wr_ti = wr & (word == (`OFS_TIMING_IRQ >> 2));
    wire       wr_ts = wr & (word == (`OFS_TIMING_STAT >> 2));
    wire       wr_fa = wr & (word == (`OFS_FUNC_ADDR >> 2));
    wire       wr_ei = wr & (word == (`OFS_EP0_IRQ >> 2));
    wire       wr_ec = wr & (word == `IDX_EP0_CTRL);

    // One wait cycle, then acknowledge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    wire for_ep0 = token_valid & mod_en_reg & (token_addr == addr_reg)
                   & (token_endp == 4'h0);
    wire setup_tok = for_ep0 & (token_kind == TOK_SETUP);
    // Only a transfer that really carried data may raise a done flag
    wire in_sent   = for_ep0 & (token_kind == TOK_IN) & ~stall_reg
                     & tx_en_reg & ~tx_f_reg;
    wire out_taken = for_ep0 & (token_kind == TOK_OUT) & ~stall_reg
                     & rx_en_reg & ~rx_f_reg;

    // ************************************************
    // Frame and packet event flags
    // ************************************************
    wire [3:0] ev = {frame_start_seen, frame_end2_point, packet_end_seen,
                     bus_activity_seen};
    wire [3:0] clr = wr_ts ? {wd[`BIT_FSTART_CLR], wd[`BIT_FEND2_CLR],
                              wd[`BIT_PEND_CLR], wd[`BIT_ACT_CLR]} : 4'h0;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_flag
            always @* begin
                flags_next[g] = ev[g] | (flags_reg[g] & ~clr[g]);
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!resetn) begin
            flags_reg  <= 4'h0;
            fr_ie_reg  <= 4'h0;
            lock_f_reg <= 1'b0;
            addr_reg   <= 7'h00;
            tx_f_reg   <= 1'b0;
            rx_f_reg   <= 1'b0;
            tx_ie_reg  <= 1'b0;
            rx_ie_reg  <= 1'b0;
            toggle_reg <= 1'b0;
            stall_reg  <= 1'b0;
            tx_en_reg  <= 1'b0;
            rx_en_reg  <= 1'b0;
            count_reg  <= 4'h0;
            ack_reg    <= 1'b0;
        end else begin
            ack_reg   <= (avs_read | avs_write) & ~ack_reg;
            flags_reg <= flags_next;
            lock_f_reg <= frame_lock_seen
                          | (lock_f_reg & ~(wr_ts & wd[`BIT_LOCK_CLR]));
            if (wr_ti)
                fr_ie_reg <= wd[3:0];
            if (wr_fa)
                addr_reg <= wd[6:0];
            if (wr_ei) begin
                tx_ie_reg <= wd[`BIT_TX_IE];
                rx_ie_reg <= wd[`BIT_RX_IE];
            end
            tx_f_reg <= (in_sent & tx_acked)
                        | (tx_f_reg & ~(wr_ei & wd[`BIT_TX_CLR]));
            rx_f_reg <= (out_taken & rx_acked)
                        | (rx_f_reg & ~(wr_ei & wd[`BIT_RX_CLR]));
            if (wr_ec) begin
                toggle_reg <= wd[`BIT_TOGGLE];
                tx_en_reg  <= wd[`BIT_TX_EN];
                rx_en_reg  <= wd[`BIT_RX_EN];
                count_reg  <= wd[3:0];
            end
            if (setup_tok)
                stall_reg <= 1'b0;
            else if (wr_ec)
                stall_reg <= wd[`BIT_STALL];
        end
    end

    // ************************************************
    // Power-on-only state
    // ************************************************
    always @(posedge clk) begin
        if (!por_n) begin
            rst_f_reg  <= 1'b0;
            mod_en_reg <= 1'b0;
        end else begin
            rst_f_reg <= bus_reset_seen
                         | (rst_f_reg & ~(wr_ts & wd[`BIT_RST_CLR]));
            if (wr_fa & wd[`BIT_MOD_EN])
                mod_en_reg <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!por_n)
            system_reset <= 1'b0;
        else
            system_reset <= bus_reset_seen;
    end

    assign regulator_output   = mod_en_reg;
    assign transceiver_enable = mod_en_reg;

    // ************************************************
    // Endpoint 0 handshake
    // ************************************************
    always @(posedge clk) begin
        if (!resetn) begin
            handshake     <= `HS_NONE;
            send_data     <= 1'b0;
            accept_data   <= 1'b0;
            data_pid_one  <= 1'b0;
            tx_byte_count <= 4'h0;
        end else begin
            handshake     <= `HS_NONE;
            send_data     <= 1'b0;
            accept_data   <= 1'b0;
            data_pid_one  <= toggle_reg;
            tx_byte_count <= count_reg;
            if (for_ep0) begin
                case (token_kind)
                    TOK_IN: begin
                        if (stall_reg)
                            handshake <= `HS_STALL;
                        else if (!tx_en_reg || tx_f_reg)
                            handshake <= `HS_NAK;
                        else
                            send_data <= 1'b1;
                    end
                    TOK_OUT: begin
                        if (stall_reg)
                            handshake <= `HS_STALL;
                        else if (!rx_en_reg || rx_f_reg)
                            handshake <= `HS_NAK;
                        else
                            accept_data <= 1'b1;
                    end
                    TOK_SETUP: accept_data <= 1'b1;
                    default: handshake <= `HS_NONE;
                endcase
            end
        end
    end

    // ************************************************
    // Interrupt and read-back
    // ************************************************
    assign usb_irq = |(flags_reg & fr_ie_reg) | (tx_f_reg & tx_ie_reg)
                     | (rx_f_reg & rx_ie_reg);

    always @(posedge clk) begin
        if (!resetn)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & ~ack_reg) begin
            case (word)
                (`OFS_TIMING_IRQ >> 2):
                    avs_readdata <= {24'h00_0000, flags_reg, fr_ie_reg};
                (`OFS_TIMING_STAT >> 2):
                    avs_readdata <= {24'h00_0000, rst_f_reg, lock_f_reg, 6'h00};
                (`OFS_FUNC_ADDR >> 2):
                    avs_readdata <= {24'h00_0000, mod_en_reg, addr_reg};
                (`OFS_EP0_IRQ >> 2):
                    avs_readdata <= {24'h00_0000, tx_f_reg, rx_f_reg, 2'h0,
                                     tx_ie_reg, rx_ie_reg, 2'h0};
                `IDX_EP0_CTRL:
                    avs_readdata <= {24'h00_0000, toggle_reg, stall_reg,
                                     tx_en_reg, rx_en_reg, count_reg};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // usb_hub_sie

// ==== hdl/usb_hub_sie_consts.vh ====
// Operation
// - Packet-end flag sets on valid end of packet; write-1 clear or reset only.
// - Bus-activity flag sets on any up/downstream line activity; write-1 clear or reset.
// - Four enables gate frame-start, frame-end2, packet-end, bus-activity onto interrupt.
// - Valid bus reset sets bus-reset flag and issues internal system reset.
// - Bus-reset flag survives all but power-on reset; write-1 clear bit clears it.
// - Frame-lock flag sets when frame timer locks; write-1 clear or reset.
// - Each write-only clear bit clears its flag on 1, ignored on 0.
// - Module enable 0 ignores tokens, turns off regulator and transceiver.
// - Module enable once set is cleared only by power-on reset.
// - Seven-bit function address, read/write, matched against tokens, reset to zero.
// - Endpoint 0 transmit flag sets after data sent and host acknowledged.
// - Endpoint 0 receive flag sets after data packet received and acknowledged.
// - Transmit and receive interrupt enables gate endpoint 0 flags; reset clears both.
// - IN to endpoint 0 gets NAK when transmit disabled or transmit flag set.
// - OUT to endpoint 0 gets NAK when receive disabled or receive flag set.
// - Toggle bit selects DATA0 or DATA1 for next IN; never hardware toggled.
// - Stall bit forces STALL to IN/OUT; cleared by SETUP token or reset.
// - Four-bit byte count for next IN response; reset clears it.
// - Frame-start flag sets on valid start-of-frame packet identifier.
// - Frame-end2 flag sets ten bit times before expected next start of frame.
`ifndef USB_HUB_SIE_CONSTS_VH
`define USB_HUB_SIE_CONSTS_VH
`define OFS_TIMING_IRQ   4'h0
`define OFS_TIMING_STAT  4'h4
`define OFS_FUNC_ADDR    4'h8
`define OFS_EP0_IRQ      4'hC
`define OFS_EP0_CTRL     8'h10
`define IDX_EP0_CTRL     4'h4
// Timing interrupt register fields
`define BIT_FSTART_F     7
`define BIT_FEND2_F      6
`define BIT_PEND_F       5
`define BIT_ACT_F        4
`define BIT_FSTART_IE    3
`define BIT_FEND2_IE     2
`define BIT_PEND_IE      1
`define BIT_ACT_IE       0
// Timing status register fields
`define BIT_RST_F        7
`define BIT_LOCK_F       6
`define BIT_RST_CLR      5
`define BIT_LOCK_CLR     4
`define BIT_FSTART_CLR   3
`define BIT_FEND2_CLR    2
`define BIT_PEND_CLR     1
`define BIT_ACT_CLR      0
// Function address register
`define BIT_MOD_EN       7
// Endpoint 0 interrupt register
`define BIT_TX_F         7
`define BIT_RX_F         6
`define BIT_TX_IE        3
`define BIT_RX_IE        2
`define BIT_TX_CLR       1
`define BIT_RX_CLR       0
// Endpoint 0 control register
`define BIT_TOGGLE       7
`define BIT_STALL        6
`define BIT_TX_EN        5
`define BIT_RX_EN        4
// Handshake codes
`define HS_NONE          2'h0
`define HS_ACK           2'h1
`define HS_NAK           2'h2
`define HS_STALL         2'h3
`endif

// ==== tb/usb_hub_sie_properties.sv ====
`timescale 1ns/100ps
// ********
// Port checks
// ********
module usb_hub_sie_properties (
    input wire       clk,
    input wire       resetn,
    input wire       por_n,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest,
    input wire       token_valid,
    input wire [1:0] token_kind,
    input wire       bus_reset_seen,
    input wire [1:0] handshake,
    input wire       send_data,
    input wire       accept_data,
    input wire       data_pid_one,
    input wire [3:0] tx_byte_count,
    input wire       system_reset,
    input wire       regulator_output,
    input wire       transceiver_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        $rose(avs_read | avs_write);
    endsequence
    sequence s_ans;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    chk_wait_one: assert property (s_req |-> s_ans)
        else $error("bus answer not after one wait");
    chk_reset_out: assert property (bus_reset_seen |=> system_reset)
        else $error("no system reset");
    chk_reset_cause: assert property (system_reset |-> $past(bus_reset_seen))
        else $error("stray system reset");
    chk_enable_hold: assert property (disable iff (!por_n || !resetn)
        regulator_output |=> regulator_output) else $error("module enable lost");
    chk_power_pair: assert property (regulator_output == transceiver_enable)
        else $error("transceiver and regulator differ");
    chk_off_silent: assert property (!regulator_output && token_valid |=>
        !send_data && !accept_data && handshake == 2'h0) else $error("disabled answer");
    chk_send_cause: assert property (send_data |-> $past(token_valid && token_kind == 2'h1))
        else $error("send without IN");
    chk_accept_cause: assert property (accept_data |-> $past(token_valid && token_kind != 2'h1))
        else $error("accept without OUT or SETUP");
    chk_toggle_sw: assert property (!$past(avs_write) && !$past(avs_write, 2) |->
        $stable(data_pid_one) && $stable(tx_byte_count)) else $error("toggle or count moved");
endmodule // usb_hub_sie_properties
bind usb_hub_sie usb_hub_sie_properties u_props (.clk, .resetn, .por_n, .avs_read, .avs_write,
    .avs_waitrequest, .token_valid, .token_kind, .bus_reset_seen, .handshake, .send_data,
    .accept_data, .data_pid_one, .tx_byte_count, .system_reset, .regulator_output,
    .transceiver_enable);

// ==== tb/host_link.sv ====
`timescale 1ns/100ps
// ********
// Upstream host
// ********
module host_link (
    input  wire        clk,
    input  wire [1:0]  handshake,
    input  wire        send_data,
    input  wire        accept_data,
    output logic       token_valid,
    output logic [1:0] token_kind,
    output logic [6:0] token_addr,
    output logic [3:0] token_endp,
    output logic       tx_acked,
    output logic       rx_acked
);
    initial {token_valid, token_kind, token_addr, token_endp, tx_acked, rx_acked} = 0;
    task tok(input [1:0] k, input [6:0] a, input [3:0] e, input ack, output [3:0] r);
        begin
            @(posedge clk);
            {token_valid, token_kind, token_addr, token_endp} <= {1'b1, k, a, e};
            {tx_acked, rx_acked} <= {ack && k == 2'h1, ack && k == 2'h0};
            @(posedge clk);
            {token_valid, tx_acked, rx_acked} <= 3'b000;
            {token_kind, token_addr, token_endp} <= ~{k, a, e};
            @(negedge clk);
            r = {handshake, send_data, accept_data};
        end
    endtask
endmodule // host_link

// ==== tb/test_usb_hub_sie.sv ====
`timescale 1ns/100ps
// ********
// Bench
// ********
module test_usb_hub_sie;
    logic        clk = 0, resetn = 0, por_n = 0, avs_read = 0, avs_write = 0;
    logic [5:0]  avs_address = 0, ev = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q, seed = 32'h0000_eb71;
    logic [3:0]  avs_byteenable = 4'hf, token_endp, tx_byte_count;
    logic [1:0]  token_kind, handshake;
    logic [6:0]  token_addr;
    logic        avs_waitrequest, token_valid, tx_acked, rx_acked, send_data, accept_data;
    logic        data_pid_one, usb_irq, system_reset, regulator_output, transceiver_enable;
    logic [7:0]  mdl [0:4];
    integer      mismatches = 0, cmp_count = 0, i;
    wire bus_activity_seen = ev[0], packet_end_seen = ev[1], frame_end2_point = ev[2];
    wire frame_start_seen = ev[3], frame_lock_seen = ev[4], bus_reset_seen = ev[5];
    always #2 clk = ~clk;
    usb_hub_sie u_usb_hub_sie (.*);
    host_link u_host_link (.*);
    function [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function irq_exp();
        return |(mdl[0][7:4] & mdl[0][3:0]) | |(mdl[3][7:6] & mdl[3][3:2]);
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input w, input [5:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge clk);
            {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 24'h00_0000, d};
            n = 0;
            @(negedge clk);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(negedge clk);
            end
            if (n == 20) mismatches = mismatches + 1;
            @(posedge clk);
            q = avs_readdata;
            {avs_write, avs_read} <= 2'b00;
        end
    endtask
    task wr(input [2:0] r, input [7:0] d);
        bus(1, {1'b0, r, 2'b00}, d);
        case (r)
            0: mdl[0][3:0] = d[3:0];
            1: begin
                mdl[1][7:6] = mdl[1][7:6] & ~d[5:4];
                mdl[0][7:4] = mdl[0][7:4] & ~d[3:0];
            end
            2: mdl[2] = {mdl[2][7] | d[7], d[6:0]};
            3: mdl[3] = {mdl[3][7] & ~d[1], mdl[3][6] & ~d[0], 2'b00, d[3:2], 2'b00};
            default: mdl[4] = d;
        endcase
    endtask
    task rd(input [3:0] r);
        logic [7:0] m;
        begin
            m = (r == 1) ? 8'hc0 : (r == 3) ? 8'hcc : 8'hff;
            bus(0, {r, 2'b00}, 8'h00);
            chk(q & {24'hff_ffff, m}, {24'h00_0000, (r > 4) ? 8'h00 : mdl[r] & m});
            chk(usb_irq, irq_exp());
            if (r == 4) chk({data_pid_one, tx_byte_count}, {mdl[4][7], mdl[4][3:0]});
        end
    endtask
    task rdall();
        for (int k = 0; k < 6; k = k + 1) rd(k[3:0]);
    endtask
    task pulse(input [2:0] n);
        @(posedge clk);
        ev <= 6'h01 << n;
        @(posedge clk);
        ev <= 6'h00;
        if (n < 4) mdl[0][4 + n] = 1'b1;
        else mdl[1][n + 2] = 1'b1;
    endtask
    task rst(input p);
        @(posedge clk);
        {resetn, por_n} <= {1'b0, !p};
        repeat (4) @(posedge clk);
        {resetn, por_n} <= 2'b11;
        {mdl[0], mdl[3], mdl[4]} = 24'h00_0000;
        mdl[1] = p ? 8'h00 : mdl[1] & 8'h80;
        mdl[2] = p ? 8'h00 : mdl[2] & 8'h80;
    endtask
    task token(input [1:0] k, input own, input ep, input ack);
        logic [3:0] r, e;
        logic       hit;
        begin
            u_host_link.tok(k, own ? mdl[2][6:0] : ~mdl[2][6:0], {3'h0, ep}, ack, r);
            hit = mdl[2][7] && own && !ep;
            e = 4'h0;
            if (hit && k == 2'h2) begin
                e = 4'h1;
                mdl[4][6] = 1'b0;
            end else if (hit && mdl[4][6]) e = 4'hc;
            else if (hit && k == 2'h1) begin
                e = (mdl[4][5] && !mdl[3][7]) ? 4'h2 : 4'h8;
                mdl[3][7] = mdl[3][7] | (e[1] & ack);
            end else if (hit) begin
                e = (mdl[4][4] && !mdl[3][6]) ? 4'h1 : 4'h8;
                mdl[3][6] = mdl[3][6] | (e[0] & ack);
            end
            chk(r, e);
        end
    endtask
    task close_out();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        for (i = 0; i < 5; i = i + 1) mdl[i] = 8'h00;
        repeat (4) @(posedge clk);
        {resetn, por_n} <= 2'b11;
        rdall();
        token(2'h1, 1, 0, 1);
        chk(regulator_output, 0);
        i = rnd();
        wr(2, {1'b1, i[6:0]});
        rd(2);
        wr(2, {1'b0, i[6:0]});
        for (i = 0; i < 6; i = i + 1) pulse(i[2:0]);
        wr(0, 8'hf0);
        rdall();
        wr(0, 8'h0f);
        wr(3, 8'h0c);
        wr(1, 8'h00);
        rdall();
        wr(1, 8'h1f);
        rst(0);
        rdall();
        wr(1, 8'h20);
        rd(1);
        for (i = 0; i < 90; i = i + 1) begin
            q = rnd();
            if (q[1:0] == 2'h0) wr(4, q[15:8]);
            else if (q[1:0] == 2'h1) wr(3, q[15:8]);
            else token(q[9:8] == 2'h3 ? 2'h2 : q[9:8], q[10] | q[11], q[12] & q[13], q[14]);
            rdall();
        end
        rst(1);
        rdall();
        token(2'h0, 1, 0, 1);
        close_out();
    end
    initial begin
        #100000;
        mismatches = mismatches + 1;
        close_out();
    end
endmodule // test_usb_hub_sie
